// ==== gofl_load.sv ====
// load on the output pins: a pull-up on every pin
// assumes oe high while the block drives the pin
`timescale 1ns/10ps
module gofl_load
  import gofl_pkg::*;
(
  input  wire logic [NUM_OUT-1:0] general_output_pin_o,
  input  wire logic [NUM_OUT-1:0] general_output_pin_oe,
  output logic      [NUM_OUT-1:0] pin_lvl
);
  // released pins float up, no keeper
  assign pin_lvl = (general_output_pin_o & general_output_pin_oe) | ~general_output_pin_oe;
endmodule

// ==== gofl_pin.sv ====
// one output pin: mode select, delay filter, polarity and drive type
// assumes ms_tick is a one-cycle pulse once per millisecond on the same clock
`timescale 1ns/10ps
module gofl_pin
  import gofl_pkg::*;
#(
  parameter int N_CH = NUM_CH
)
(
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            ms_tick,
  input  wire logic [31:0]     cfg,
  input  wire logic [N_CH-1:0] ok_in,
  input  wire logic [N_CH-1:0] alarm_in,
  input  wire logic            alt_val,
  input  wire logic            alt_oe,
  output logic                 pin_o,
  output logic                 pin_oe,
  output logic                 asserted
);
  logic [2:0]       func;
  logic [N_CH-1:0]  mask;
  logic             comb_in;
  logic             filt_mode;
  logic             want;
  logic [DLY_W-1:0] target_ms;
  logic             filt_ff,   nxt_filt;
  logic [DLY_W-1:0] cnt_ff,    nxt_cnt;
  logic             pin_ff,    nxt_pin;
  logic             oe_ff,     nxt_oe;
  logic             act_ff,    nxt_act;

  assign func      = cfg[FUNC_LSB +: 3];
  assign mask      = cfg[MASK_LSB +: N_CH];
  // mask only matters in the two combinational modes
  assign filt_mode = (func == FN_AND) || (func == FN_OR);
  always_comb
  begin
    comb_in = 1'b0;
    if (func == FN_AND)
      comb_in = &(ok_in | ~mask);
    else if (func == FN_OR)
      comb_in = |(alarm_in & mask);
  end
  // table + extra + 1 ticks; tick phase puts the lag at 2..3 ms past the table
  assign target_ms = gofl_dly_ms(comb_in ? cfg[ON_DLY_LSB +: 4] : cfg[OFF_DLY_LSB +: 4]);

  always_comb
  begin
    nxt_filt = filt_ff;
    nxt_cnt  = cnt_ff;
    if (!filt_mode)
    begin
      nxt_cnt  = '0;
      nxt_filt = 1'b0;
    end
    else if (comb_in == filt_ff)
      nxt_cnt = '0;                                             // any change restarts the wait
    else if (ms_tick)
    begin
      if (cnt_ff >= target_ms + DLY_W'(EXTRA_MS))
      begin
        nxt_filt = comb_in;
        nxt_cnt  = '0;
      end
      else
        nxt_cnt = cnt_ff + 1'b1;
    end
    // input flipped back before expiry: counter cleared above
    case (func)
      FN_ON:   want = 1'b1;
      FN_OFF:  want = 1'b0;
      FN_AND,
      FN_OR:   want = filt_ff;
      default: want = 1'b0;                                     // reserved codes stay inactive
    endcase
    nxt_act = want;
    if (func == FN_ALT)
    begin
      nxt_pin = alt_val;
      nxt_oe  = alt_oe;
    end
    else
    begin
      // level = asserted xnor active-high choice
      nxt_pin = ~(want ^ cfg[POL_BIT]);
      // open drain only pulls low
      nxt_oe  = cfg[DRIVE_BIT] ? ~nxt_pin : 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_ff <= 1'b0;
      cnt_ff  <= '0;
      pin_ff  <= 1'b0;
      oe_ff   <= 1'b0;
      act_ff  <= 1'b0;
    end
    else
    begin
      filt_ff <= nxt_filt;
      cnt_ff  <= nxt_cnt;
      pin_ff  <= nxt_pin;
      oe_ff   <= nxt_oe;
      act_ff  <= nxt_act;
    end
  end

  assign pin_o    = pin_ff;
  assign pin_oe   = oe_ff;
  assign asserted = act_ff;
endmodule

// ==== gofl_pkg.sv ====
// package for the general output function logic: register layout, codes, timing
// assumes a 100 MHz core clock and pages 21..28 for the eight outputs
package gofl_pkg;
  localparam int          NUM_OUT        = 8;
  localparam int          NUM_CH         = 16;
  localparam logic [7:0]  CFG_CMD_CODE   = 8'hF8;
  localparam logic [7:0]  FIRST_PAGE     = 8'h15;
  localparam logic [7:0]  LAST_PAGE      = 8'h1C;
  localparam logic [7:0]  ORDER_PAGE     = 8'h19;
  localparam logic [7:0]  ALIGN_PAGE     = 8'h1C;
  localparam logic [7:0]  HIZ_PAGE_A     = 8'h1A;
  localparam logic [7:0]  HIZ_PAGE_B     = 8'h1B;
  localparam int          MASK_LSB       = 16;
  localparam int          OFF_DLY_LSB    = 12;
  localparam int          ON_DLY_LSB     = 8;
  localparam int          DRIVE_BIT      = 7;
  localparam int          POL_BIT        = 6;
  localparam int          FUNC_LSB       = 0;
  localparam logic [31:0] CFG_WR_MASK    = 32'hFFFF_FFC7;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  localparam int          CLK_MHZ        = 100;
  localparam int          MS_NS          = 1000000;
  localparam int          CLK_NS         = 1000 / CLK_MHZ;
  localparam int          MS_CYCLES      = MS_NS / CLK_NS;
  localparam int          EXTRA_MS       = 2;
  localparam int          DLY_W          = 13;

  typedef enum logic [2:0]
  {
    FN_ALT   = 3'h0,
    FN_ON    = 3'h1,
    FN_OFF   = 3'h2,
    FN_AND   = 3'h3,
    FN_OR    = 3'h4
  } gofl_func_t;

  // delay code to milliseconds
  function automatic logic [DLY_W-1:0] gofl_dly_ms(input logic [3:0] code);
    case (code)
      4'h0:    gofl_dly_ms = 13'h0000;
      4'h1:    gofl_dly_ms = 13'h0005;
      4'h2:    gofl_dly_ms = 13'h000A;
      4'h3:    gofl_dly_ms = 13'h0014;
      4'h4:    gofl_dly_ms = 13'h0028;
      4'h5:    gofl_dly_ms = 13'h003C;
      4'h6:    gofl_dly_ms = 13'h0050;
      4'h7:    gofl_dly_ms = 13'h0064;
      4'h8:    gofl_dly_ms = 13'h00C8;
      4'h9:    gofl_dly_ms = 13'h0190;
      4'hA:    gofl_dly_ms = 13'h0258;
      4'hB:    gofl_dly_ms = 13'h0320;
      4'hC:    gofl_dly_ms = 13'h03E8;
      4'hD:    gofl_dly_ms = 13'h05DC;
      4'hE:    gofl_dly_ms = 13'h07D0;
      default: gofl_dly_ms = 13'h0FA0;
    endcase
  endfunction
endpackage

// ==== gofl_props.sv ====
// checker for gofl_top: config readback and pin modes
// assumes a bind to gofl_top; config is shadowed from the write port
`timescale 1ns/10ps
module gofl_props
  import gofl_pkg::*;
#(
  parameter int N_OUT = NUM_OUT,
  parameter int N_CH  = NUM_CH,
  parameter int TICK  = MS_CYCLES
)
(
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic [7:0]       page,
  input wire logic [7:0]       cmd,
  input wire logic             wr_en,
  input wire logic [31:0]      wr_data,
  input wire logic [31:0]      rd_data,
  input wire logic             rd_hit,
  input wire logic [N_CH-1:0]  power_ok,
  input wire logic [N_CH-1:0]  chan_alarm,
  input wire logic [3:0]       failure_out_src,
  input wire logic             ordering_signal_src,
  input wire logic             align_src,
  input wire logic [N_OUT-1:0] general_output_pin_o,
  input wire logic [N_OUT-1:0] general_output_pin_oe,
  input wire logic [N_OUT-1:0] pin_asserted
);
  logic [31:0] sh_ff [N_OUT];
  logic [31:0] nxt_sh [N_OUT];
  logic [31:0] rd_ff;
  logic        hit_ff;
  wire logic   aok = (cmd == CFG_CMD_CODE) && (page >= FIRST_PAGE) && (page <= LAST_PAGE);
  wire logic [2:0] pix = 3'(page - FIRST_PAGE);
  always_comb
  begin
    nxt_sh = sh_ff;
    if (wr_en && aok)
      nxt_sh[pix] = wr_data & CFG_WR_MASK;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_ff  <= '{default: CFG_RESET};
      rd_ff  <= 32'h0000_0000;
      hit_ff <= 1'b0;
    end
    else
    begin
      sh_ff  <= nxt_sh;
      rd_ff  <= aok ? sh_ff[pix] : 32'h0000_0000;
      hit_ff <= aok;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rd_data; rd_hit |-> rd_data == rd_ff; endproperty
  a_rd_data: assert property (p_rd_data) else $error("readback wrong");
  property p_rd_hit; rd_hit == hit_ff; endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("hit flag wrong");
  property p_rd_miss; !rd_hit |-> rd_data == 32'h0000_0000; endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("miss data not zero");
  for (genvar i = 0; i < N_OUT; i++)
  begin : g_pin
    wire logic [2:0] fn  = sh_ff[i][2:0];
    wire logic       od  = sh_ff[i][DRIVE_BIT];
    wire logic       lvl = pin_asserted[i] ~^ sh_ff[i][POL_BIT];
    sequence s_fn(logic [2:0] f); fn == f ##1 fn == f; endsequence
    sequence s_frc; ((fn == FN_ON || fn == FN_OFF) && $stable(sh_ff[i]))[*2]; endsequence
    property p_on; s_fn(FN_ON) |-> pin_asserted[i]; endproperty
    a_on: assert property (p_on) else $error("forced on lost");
    property p_off; s_fn(FN_OFF) |-> !pin_asserted[i]; endproperty
    a_off: assert property (p_off) else $error("forced off lost");
    property p_rsv; (fn > FN_OR)[*2] |-> !pin_asserted[i]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved code asserts");
    property p_push; s_frc ##0 !od |-> general_output_pin_oe[i] && general_output_pin_o[i] == lvl; endproperty
    a_push: assert property (p_push) else $error("push-pull level wrong");
    property p_open; s_frc ##0 od |-> general_output_pin_o[i] == lvl && general_output_pin_oe[i] == !lvl; endproperty
    a_open: assert property (p_open) else $error("open-drain drive wrong");
    property p_hiz; s_fn(FN_ALT) ##0 (i == 5 || i == 6) |-> !general_output_pin_oe[i]; endproperty
    a_hiz: assert property (p_hiz) else $error("alternate not released");
    property p_blk; fn == FN_OFF ##1 (fn == FN_OR && sh_ff[i][31:16] == 16'h0000)[*4] |-> !pin_asserted[i]; endproperty
    a_blk: assert property (p_blk) else $error("blocked alarm asserts");
  end
endmodule
bind gofl_top gofl_props #(.N_OUT(N_OUT), .N_CH(N_CH), .TICK(TICK)) u_props (.ref_clk(ref_clk), .rst_n(rst_n),
  .page(page), .cmd(cmd), .wr_en(wr_en), .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit),
  .power_ok(power_ok), .chan_alarm(chan_alarm), .failure_out_src(failure_out_src),
  .ordering_signal_src(ordering_signal_src), .align_src(align_src), .general_output_pin_o(general_output_pin_o),
  .general_output_pin_oe(general_output_pin_oe), .pin_asserted(pin_asserted));

// ==== gofl_top.sv ====
// general output function logic for eight paged output pins
// assumes a command decoder presents page, command, write strobe and data on ref_clk
// Behaviour
// - code 000 gives pin its alternate function
// - pages 21..28 select outputs and alternates
// - codes 001/010 force asserted/deasserted
// - code 011 ands selected power-ok inputs
// - mask bit channel plus 16 includes
// - mask used only for codes 011, 100
// - code 100 ors selected channel alarms
// - masked-off alarms never affect output
// - codes 101..111 define no behaviour
// - delay codes map 0..4000 ms table
// - delays apply only in and/or modes
// - output may lag delay by 2-3 ms
// - input must stay static whole delay
// - bit 7 push-pull or open-drain
// - bits 5:3 always read zero
`timescale 1ns/10ps
module gofl_top
  import gofl_pkg::*;
#(
  parameter int N_OUT = NUM_OUT,
  parameter int N_CH  = NUM_CH,
  parameter int TICK  = MS_CYCLES
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [7:0]       page,
  input  wire logic [7:0]       cmd,
  input  wire logic             wr_en,
  input  wire logic [31:0]      wr_data,
  output logic      [31:0]      rd_data,
  output logic                  rd_hit,
  input  wire logic [N_CH-1:0]  power_ok,
  input  wire logic [N_CH-1:0]  chan_alarm,
  input  wire logic [3:0]       failure_out_src,
  input  wire logic             ordering_signal_src,
  input  wire logic             align_src,
  output logic      [N_OUT-1:0] general_output_pin_o,
  output logic      [N_OUT-1:0] general_output_pin_oe,
  output logic      [N_OUT-1:0] pin_asserted
);
  logic            rst_s1_ff, rst_s2_ff;
  logic            nxt_rst_s1, nxt_rst_s2;
  logic            rst_int_n;
  logic [N_CH-1:0] ok_s1_ff,  ok_s2_ff;
  logic [N_CH-1:0] nxt_ok_s1, nxt_ok_s2;
  logic [N_CH-1:0] alm_s1_ff, alm_s2_ff;
  logic [N_CH-1:0] nxt_alm_s1, nxt_alm_s2;
  logic [31:0]     cfg_ff [N_OUT];
  logic [31:0]     nxt_cfg [N_OUT];
  logic [31:0]     tick_cnt_ff, nxt_tick_cnt;
  logic            tick_ff, nxt_tick;
  logic [31:0]     rd_ff, nxt_rd;
  logic            hit_ff, nxt_hit;
  logic [N_OUT-1:0] alt_val;
  logic [N_OUT-1:0] alt_oe;

  function automatic logic page_ok(input logic [7:0] p);
    page_ok = (p >= FIRST_PAGE) && (p <= LAST_PAGE);
  endfunction

  // page that addresses output i
  function automatic logic [7:0] pin_page(input int i);
    pin_page = FIRST_PAGE + 8'(i);
  endfunction

  // only the release edge is retimed; entry into reset stays asynchronous
  always_comb
  begin
    nxt_rst_s1 = 1'b1;
    nxt_rst_s2 = rst_s1_ff;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= nxt_rst_s1;
      rst_s2_ff <= nxt_rst_s2;
    end
  end
  assign rst_int_n = rst_s2_ff;

  // channel inputs come from pins, so two stages first
  always_comb
  begin
    nxt_ok_s1  = power_ok;
    nxt_ok_s2  = ok_s1_ff;
    nxt_alm_s1 = chan_alarm;
    nxt_alm_s2 = alm_s1_ff;
  end

  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      ok_s1_ff  <= '0;
      ok_s2_ff  <= '0;
      alm_s1_ff <= '0;
      alm_s2_ff <= '0;
    end
    else
    begin
      ok_s1_ff  <= nxt_ok_s1;
      ok_s2_ff  <= nxt_ok_s2;
      alm_s1_ff <= nxt_alm_s1;
      alm_s2_ff <= nxt_alm_s2;
    end
  end

  always_comb
  begin
    nxt_tick     = 1'b0;
    nxt_tick_cnt = tick_cnt_ff + 32'h1;
    if (tick_cnt_ff >= 32'(TICK - 1))
    begin
      nxt_tick_cnt = '0;
      nxt_tick     = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end
    else
    begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  // rewrites take effect at once; quiet-time is left to software
  always_comb
  begin
    for (int i = 0; i < N_OUT; i++)
    begin
      nxt_cfg[i] = cfg_ff[i];
      if (wr_en && (cmd == CFG_CMD_CODE) && (page == pin_page(i)))
        nxt_cfg[i] = wr_data & CFG_WR_MASK;
    end
    nxt_hit = (cmd == CFG_CMD_CODE) && page_ok(page);
    nxt_rd  = '0;
    if (nxt_hit)
      nxt_rd = cfg_ff[3'(page - FIRST_PAGE)];
  end

  always_ff @(posedge ref_clk or negedge rst_int_n)
  begin
    if (!rst_int_n)
    begin
      for (int i = 0; i < N_OUT; i++)
        cfg_ff[i] <= CFG_RESET;
      rd_ff       <= '0;
      hit_ff      <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < N_OUT; i++)
        cfg_ff[i] <= nxt_cfg[i];
      rd_ff       <= nxt_rd;
      hit_ff      <= nxt_hit;
    end
  end
  assign rd_data = rd_ff;
  assign rd_hit  = hit_ff;

  // alternate functions: open-drain low-active signals drive only when low
  always_comb
  begin
    for (int i = 0; i < N_OUT; i++)
    begin
      alt_val[i] = 1'b0;
      alt_oe[i]  = 1'b0;
      if (pin_page(i) < ORDER_PAGE)
      begin
        alt_val[i] = ~failure_out_src[i];
        alt_oe[i]  = failure_out_src[i];
      end
      else if (pin_page(i) == ORDER_PAGE)
      begin
        alt_val[i] = ~ordering_signal_src;
        alt_oe[i]  = ordering_signal_src;
      end
      else if (pin_page(i) == ALIGN_PAGE)
      begin
        alt_val[i] = align_src;
        alt_oe[i]  = 1'b1;
      end
      // remaining pages stay high impedance
    end
  end

  for (genvar g = 0; g < N_OUT; g++)
  begin : g_pin
    gofl_pin #(.N_CH(N_CH)) u_pin
    (
      .ref_clk  (ref_clk),
      .rst_n    (rst_int_n),
      .ms_tick  (tick_ff),
      .cfg      (cfg_ff[g]),
      .ok_in    (ok_s2_ff),
      .alarm_in (alm_s2_ff),
      .alt_val  (alt_val[g]),
      .alt_oe   (alt_oe[g]),
      .pin_o    (general_output_pin_o[g]),
      .pin_oe   (general_output_pin_oe[g]),
      .asserted (pin_asserted[g])
    );
  end
endmodule

// ==== gofl_top_tb.sv ====
// self-checking bench for gofl_top: readback, forced, logic, delay and alternate modes
// assumes 100 MHz ref_clk and a millisecond shortened to TK cycles
`timescale 1ns/10ps
module gofl_top_tb
  import gofl_pkg::*;
;
  localparam int TK = 10;
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic [7:0]         page = 8'h00;
  logic [7:0]         cmd = 8'h00;
  logic               wr_en = 1'b0;
  logic [31:0]        wr_data = 32'h0;
  logic [NUM_CH-1:0]  power_ok = '0;
  logic [NUM_CH-1:0]  chan_alarm = '0;
  logic [3:0]         failure_out_src = 4'h0;
  logic               ordering_signal_src = 1'b0;
  logic               align_src = 1'b0;
  logic [31:0]        rd_data;
  logic               rd_hit;
  logic [NUM_OUT-1:0] pin_o, pin_oe, pin_asserted, pin_lvl;
  int                 num_errors = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  always #5 ref_clk = ~ref_clk;
  gofl_top #(.TICK(TK)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .page(page), .cmd(cmd), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit), .power_ok(power_ok), .chan_alarm(chan_alarm),
    .failure_out_src(failure_out_src), .ordering_signal_src(ordering_signal_src), .align_src(align_src),
    .general_output_pin_o(pin_o), .general_output_pin_oe(pin_oe), .pin_asserted(pin_asserted));
  gofl_load u_load (.general_output_pin_o(pin_o), .general_output_pin_oe(pin_oe), .pin_lvl(pin_lvl));
  task automatic close_out();
    $display("comparisons=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      close_out();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // config changes only between runs of the inputs
  task automatic wr(input logic [7:0] p, input logic [31:0] d);
    page = p;
    cmd = CFG_CMD_CODE;
    wr_data = d;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] p, input logic [31:0] e, input logic h);
    cmd = c;
    page = p;
    cyc(1);
    chk(rd_data, e);
    chk({31'h0, rd_hit}, {31'h0, h});
  endtask
  task automatic pin(input int i, input logic [1:0] e);
    chk({30'h0, pin_asserted[i], pin_lvl[i]}, {30'h0, e});
  endtask
  task automatic t_regs();
    rd(CFG_CMD_CODE, 8'h16, 32'h0, 1'b1);
    wr(FIRST_PAGE, 32'hFFFF_FFFF);
    wr(8'h14, 32'h0000_0001);
    wr(LAST_PAGE, 32'h1234_5FFA);
    rd(CFG_CMD_CODE, FIRST_PAGE, 32'hFFFF_FFC7, 1'b1);
    rd(CFG_CMD_CODE, LAST_PAGE, 32'h1234_5FC2, 1'b1);
    rd(CFG_CMD_CODE, 8'h14, 32'h0, 1'b0);
    rd(8'hF0, FIRST_PAGE, 32'h0, 1'b0);
    $display("t_regs done");
  endtask
  task automatic t_modes();
    logic [7:0] mb [10] = '{8'h01, 8'h41, 8'h81, 8'hC1, 8'h02, 8'h42, 8'h82, 8'h45, 8'h46, 8'h47};
    logic [1:0] me [10] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
    power_ok = '1;
    chan_alarm = '1;
    for (int i = 0; i < 10; i++)
    begin
      // mask and long delays set too: forced modes ignore them
      wr(FIRST_PAGE, {24'hFFFF_FF, mb[i]});
      cyc(2);
      pin(0, me[i]);
    end
    $display("t_modes done");
  endtask
  task automatic t_logic();
    power_ok = 16'h0001;
    wr(8'h16, 32'h0009_0003);
    cyc(4 * TK);
    pin(1, 2'h1);
    power_ok = 16'h0009;
    cyc(4 * TK);
    pin(1, 2'h2);
    power_ok = 16'hFFF7;
    cyc(4 * TK);
    pin(1, 2'h1);
    wr(8'h17, 32'h0000_0002);
    wr(8'h17, 32'h0000_0044);
    cyc(4 * TK);
    pin(2, 2'h0);
    chan_alarm = 16'h0002;
    wr(8'h17, 32'h0004_0044);
    cyc(4 * TK);
    pin(2, 2'h0);
    chan_alarm = 16'h0006;
    cyc(4 * TK);
    pin(2, 2'h3);
    $display("t_logic done");
  endtask
  task automatic t_delay();
    int n;
    power_ok = 16'h0000;
    wr(8'h18, 32'h0001_0103);
    cyc(4 * TK);
    power_ok = 16'h0001;
    cyc(4 * TK);
    power_ok = 16'h0000;
    cyc(3);
    power_ok = 16'h0001;
    for (n = 0; n < 200 && pin_asserted[3] !== 1'b1; n++)
      cyc(1);
    chk(32'(n >= 68 && n <= 86), 32'h1);
    $display("t_delay done");
  endtask
  task automatic t_alt();
    wr(FIRST_PAGE, 32'h0);
    wr(ORDER_PAGE, 32'h0);
    wr(HIZ_PAGE_A, 32'h0);
    wr(ALIGN_PAGE, 32'h0);
    failure_out_src = 4'h1;
    ordering_signal_src = 1'b1;
    align_src = 1'b1;
    cyc(4);
    chk({28'h0, pin_lvl[0], pin_lvl[4], pin_oe[5], pin_lvl[7]}, 32'h1);
    failure_out_src = 4'h0;
    ordering_signal_src = 1'b0;
    align_src = 1'b0;
    cyc(4);
    chk({28'h0, pin_lvl[0], pin_lvl[4], pin_oe[5], pin_lvl[7]}, 32'hC);
    $display("t_alt done");
  endtask
  initial
  begin
    cyc(2);
    rst_n = 1'b1;
    cyc(3);
    t_regs();
    t_modes();
    t_logic();
    t_delay();
    t_alt();
    close_out();
  end
endmodule
